/* File: rtl/spisr_pkg.sv */
`default_nettype none
package spisr_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DATA   = 8'h21;
  localparam logic [7:0] IDX_CTRL   = 8'h22;
  localparam logic [7:0] IDX_STATUS = 8'h23;

  // status bit positions
  localparam int POS_DONE   = 7;
  localparam int POS_WRITE_COLLISION_FLAG   = 6;
  localparam int POS_OVR    = 5;
  localparam int POS_MODE_FAULT_FLAG   = 4;
  localparam int POS_SOD    = 2;
  localparam int POS_SSM    = 1;
  localparam int POS_SSI    = 0;

  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [2:0] CFG_RESET    = 3'h0;
  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam int         SYNC_STAGES  = 2;

  // sck half periods in core clocks for each divider
  localparam logic [6:0] HALF_DIV4    = 7'h02;
  localparam logic [6:0] HALF_DIV8    = 7'h04;
  localparam logic [6:0] HALF_DIV16   = 7'h08;
  localparam logic [6:0] HALF_DIV32   = 7'h10;
  localparam logic [6:0] HALF_DIV64   = 7'h20;
  localparam logic [6:0] HALF_DIV128  = 7'h40;

  typedef struct packed {
    logic       irq_enable;
    logic       port_enable;
    logic       rate_hi;
    logic       master_select;
    logic       clk_pol;
    logic       clk_pha;
    logic [1:0] rate_lo;
  } spisr_ctrl_t;

  typedef struct packed {
    logic output_disable;
    logic select_source_software;
    logic internal_select_level;
  } spisr_cfg_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } spisr_pins_t;

  // synchroniser reset value: select line at its deselected level
  localparam spisr_pins_t PINS_RESET = '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};

endpackage
`default_nettype wire

/* File: rtl/spisr_shifter.sv */
`timescale 1ns/100ps
`default_nettype none
module spisr_shifter
  import spisr_pkg::*;
#(
  parameter int BITS = 8
)
(
  input  wire logic            clk_i,
  input  wire logic            srst_i,
  input  wire logic            enable_i,
  input  wire logic            master_i,
  input  wire logic            cpol_i,
  input  wire logic            cpha_i,
  input  wire logic            selected_i,
  input  wire logic [6:0]      half_i,
  input  wire logic            sck_in_i,
  input  wire logic            sdi_i,
  input  wire logic            load_i,
  input  wire logic [BITS-1:0] tx_i,
  output logic                 sck_o,
  output logic                 sdo_o,
  output logic                 busy_o,
  output logic                 done_o,
  output logic [BITS-1:0]      rx_o
);

  logic [BITS-1:0] shreg;
  logic [3:0]      cnt;
  logic [6:0]      div_cnt;
  logic            sck_q;
  logic            sck_prev;
  logic            mbusy;
  logic            last_q;
  logic            tog;
  logic            chg;
  logic            lead;
  logic            trail;
  logic            sample;
  logic            shift;
  logic            done_now;

  assign tog      = mbusy && (div_cnt == half_i - 7'h01);
  assign chg      = !master_i && selected_i && (sck_in_i != sck_prev);
  assign lead     = master_i ? (tog && sck_q == cpol_i) : (chg && sck_prev == cpol_i);
  assign trail    = master_i ? (tog && sck_q != cpol_i) : (chg && sck_prev != cpol_i);
  assign sample   = cpha_i ? trail : lead;
  assign shift    = cpha_i ? lead : trail;
  assign done_now = sample && (cnt == 4'(BITS - 1));
  assign busy_o   = mbusy || (!master_i && selected_i && cnt != 4'h0);
  assign rx_o     = shreg;
  assign sck_o    = sck_q;

  always_ff @(posedge clk_i)
  begin
    sck_prev <= sck_in_i;
  end

  // master clock generation
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !enable_i || !mbusy)
    begin
      div_cnt <= 7'h00;
      sck_q   <= cpol_i;
    end
    else if (tog)
    begin
      div_cnt <= 7'h00;
      sck_q   <= !sck_q;
    end
    else
    begin
      div_cnt <= div_cnt + 7'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i || !enable_i)
    begin
      mbusy  <= 1'b0;
      last_q <= 1'b0;
    end
    else if (load_i && master_i)
    begin
      mbusy  <= 1'b1;
      last_q <= 1'b0;
    end
    else if (trail && (last_q || done_now))
    begin
      mbusy  <= 1'b0;
      last_q <= 1'b0;
    end
    else if (done_now)
    begin
      last_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i || !enable_i || (!master_i && !selected_i))
    begin
      cnt <= 4'h0;
    end
    else if (done_now)
    begin
      cnt <= 4'h0;
    end
    else if (sample)
    begin
      cnt <= cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      shreg <= '0;
      sdo_o <= 1'b0;
    end
    else if (load_i)
    begin
      shreg <= tx_i;
      sdo_o <= tx_i[BITS-1];
    end
    else
    begin
      if (sample)
      begin
        shreg <= {shreg[BITS-2:0], sdi_i};
      end
      if (shift)
      begin
        sdo_o <= shreg[BITS-1];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= enable_i && done_now;
    end
  end

endmodule // spisr_shifter
`default_nettype wire

/* File: rtl/spisr_top.sv */
`timescale 1ns/100ps
`default_nettype none
module spisr_top
  import spisr_pkg::*;
#(
  parameter int BITS = 8
)
(
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_n_o,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe_n_o,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe_n_o,
  input  wire logic        ss_n_i,
  output logic             ss_pin_free_o,
  output logic             irq_o
);

  spisr_ctrl_t     ctrl;
  spisr_cfg_t      cfg;
  spisr_pins_t     pin_meta;
  spisr_pins_t     pin_sync;
  logic [BITS-1:0] rx_buffer;
  logic            transfer_done_flag;
  logic            write_collision_flag;
  logic            overrun_flag;
  logic            mode_fault_flag;
  logic            done_armed;
  logic            status_read_seen;
  logic            write_collision_flag_armed;
  logic            mode_fault_flag_armed;
  logic            ack;
  logic            req;
  logic            fire;
  logic            data_rd;
  logic            data_wr;
  logic            ctrl_rd;
  logic            ctrl_wr;
  logic            stat_rd;
  logic            stat_wr;
  logic            ss_level;
  logic            selected;
  logic            fault;
  logic            wr_blocked;
  logic            load;
  logic            busy;
  logic            done;
  logic            sdo;
  logic            sck_gen;
  logic [BITS-1:0] rx_shift;
  logic [7:0]      status_word;

  function automatic logic [6:0] half_period(input logic [2:0] rate);
    case (rate)
      3'h4:    half_period = HALF_DIV4;
      3'h0:    half_period = HALF_DIV8;
      3'h1:    half_period = HALF_DIV16;
      3'h6:    half_period = HALF_DIV32;
      3'h2:    half_period = HALF_DIV64;
      default: half_period = HALF_DIV128;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] idx);
    hit = (addr == idx);
  endfunction

  // pin synchronisers
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      pin_meta <= PINS_RESET;
      pin_sync <= PINS_RESET;
    end
    else
    begin
      pin_meta <= '{sck: sck_i, mosi: mosi_i, miso: miso_i, ss_n: ss_n_i};
      pin_sync <= pin_meta;
    end
  end

  // bus slave: one wait cycle, then accept
  assign req               = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req && !ack;
  assign fire              = req && ack;
  assign data_rd           = fire && avs_read_i && hit(avs_address_i, IDX_DATA);
  assign data_wr           = fire && avs_write_i && hit(avs_address_i, IDX_DATA);
  assign ctrl_rd           = fire && avs_read_i && hit(avs_address_i, IDX_CTRL);
  assign ctrl_wr           = fire && avs_write_i && hit(avs_address_i, IDX_CTRL);
  assign stat_rd           = fire && avs_read_i && hit(avs_address_i, IDX_STATUS);
  assign stat_wr           = fire && avs_write_i && hit(avs_address_i, IDX_STATUS);

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      ack <= 1'b0;
    end
    else
    begin
      ack <= req && !ack;
    end
  end

  always_comb
  begin
    status_word           = 8'h00;
    status_word[POS_DONE] = transfer_done_flag;
    status_word[POS_WRITE_COLLISION_FLAG] = write_collision_flag;
    status_word[POS_OVR]  = overrun_flag;
    status_word[POS_MODE_FAULT_FLAG] = mode_fault_flag;
    status_word[POS_SOD]  = cfg.output_disable;
    status_word[POS_SSM]  = cfg.select_source_software;
    status_word[POS_SSI]  = cfg.internal_select_level;
  end

  // read data captured while waitrequest is high
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      avs_readdata_o <= 32'h0000_0000;
    end
    else if (avs_read_i && !ack)
    begin
      if (hit(avs_address_i, IDX_DATA))
      begin
        avs_readdata_o <= {24'h00_0000, rx_buffer};
      end
      else if (hit(avs_address_i, IDX_CTRL))
      begin
        avs_readdata_o <= {24'h00_0000, ctrl};
      end
      else if (hit(avs_address_i, IDX_STATUS))
      begin
        avs_readdata_o <= {24'h00_0000, status_word};
      end
      else
      begin
        avs_readdata_o <= 32'h0000_0000;
      end
    end
  end

  // slave select source
  assign ss_level      = cfg.select_source_software ? cfg.internal_select_level : pin_sync.ss_n;
  assign selected      = !ss_level;
  assign ss_pin_free_o = cfg.select_source_software;
  assign fault         = ctrl.master_select && selected;

  // control register
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      ctrl <= CTRL_RESET;
    end
    else if (fault)
    begin
      ctrl.port_enable   <= 1'b0;
      ctrl.master_select <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      ctrl <= avs_writedata_i[7:0];
    end
  end

  // configuration bits of the status register
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      cfg <= CFG_RESET;
    end
    else if (stat_wr)
    begin
      cfg <= avs_writedata_i[2:0];
    end
  end

  // transfer done flag and its clear sequence
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      transfer_done_flag <= 1'b0;
    end
    else if (done)
    begin
      transfer_done_flag <= 1'b1;
    end
    else if (done_armed && (data_rd || data_wr))
    begin
      transfer_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      done_armed       <= 1'b0;
      status_read_seen <= 1'b0;
    end
    else if (stat_rd || stat_wr)
    begin
      done_armed       <= 1'b1;
      status_read_seen <= stat_rd || status_read_seen;
    end
    else if (data_rd || data_wr)
    begin
      done_armed       <= 1'b0;
      status_read_seen <= 1'b0;
    end
  end

  // write acceptance
  assign wr_blocked = transfer_done_flag && !status_read_seen;
  assign load       = data_wr && !wr_blocked && !busy && ctrl.port_enable;

  // write collision
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      write_collision_flag <= 1'b0;
    end
    else if (data_wr && busy)
    begin
      write_collision_flag <= 1'b1;
    end
    else if (write_collision_flag_armed && data_rd)
    begin
      write_collision_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      write_collision_flag_armed <= 1'b0;
    end
    else if (stat_rd)
    begin
      write_collision_flag_armed <= 1'b1;
    end
    else if (data_rd || data_wr)
    begin
      write_collision_flag_armed <= 1'b0;
    end
  end

  // overrun
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      overrun_flag <= 1'b0;
    end
    else if (done && transfer_done_flag)
    begin
      overrun_flag <= 1'b1;
    end
    else if (stat_rd && avs_readdata_o[POS_OVR])
    begin
      // clear only what this read reported
      overrun_flag <= 1'b0;
    end
  end

  // mode fault
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      mode_fault_flag <= 1'b0;
    end
    else if (fault)
    begin
      mode_fault_flag <= 1'b1;
    end
    else if (mode_fault_flag_armed && ctrl_wr)
    begin
      mode_fault_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      mode_fault_flag_armed <= 1'b0;
    end
    else if (mode_fault_flag_armed && ctrl_wr)
    begin
      mode_fault_flag_armed <= 1'b0;
    end
    else if (mode_fault_flag && (ctrl_rd || ctrl_wr))
    begin
      mode_fault_flag_armed <= 1'b1;
    end
  end

  // read buffer, kept on overrun
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      rx_buffer <= BITS'(DATA_RESET);
    end
    else if (done && !transfer_done_flag)
    begin
      rx_buffer <= rx_shift;
    end
  end

  assign irq_o = ctrl.irq_enable && (transfer_done_flag || overrun_flag || mode_fault_flag);

  spisr_shifter #(
    .BITS (BITS)
  ) u_shifter (
    .clk_i      (core_clk_i),
    .srst_i     (srst_i),
    .enable_i   (ctrl.port_enable),
    .master_i   (ctrl.master_select),
    .cpol_i     (ctrl.clk_pol),
    .cpha_i     (ctrl.clk_pha),
    .selected_i (selected),
    .half_i     (half_period({ctrl.rate_hi, ctrl.rate_lo})),
    .sck_in_i   (pin_sync.sck),
    .sdi_i      (ctrl.master_select ? pin_sync.miso : pin_sync.mosi),
    .load_i     (load),
    .tx_i       (avs_writedata_i[BITS-1:0]),
    .sck_o      (sck_gen),
    .sdo_o      (sdo),
    .busy_o     (busy),
    .done_o     (done),
    .rx_o       (rx_shift)
  );

  // pin drivers, enables active low
  assign sck_o       = sck_gen;
  assign mosi_o      = sdo;
  assign miso_o      = sdo;
  assign sck_oe_n_o  = !(ctrl.port_enable && ctrl.master_select);
  assign mosi_oe_n_o = !(ctrl.port_enable && ctrl.master_select && !cfg.output_disable);
  assign miso_oe_n_o = !(ctrl.port_enable && !ctrl.master_select && selected && !cfg.output_disable);

endmodule // spisr_top
`default_nettype wire

/* File: verif/spisr_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module spisr_asserts
  import spisr_pkg::*;
#(
  parameter int BITS = 8
)
(
  input wire logic        core_clk_i,
  input wire logic        srst_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        sck_oe_n_o,
  input wire logic        mosi_oe_n_o,
  input wire logic        miso_oe_n_o,
  input wire logic        ss_n_i,
  input wire logic        ss_pin_free_o,
  input wire logic        irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  wire logic st_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == IDX_STATUS;
  wire logic odd   = avs_address_i < IDX_DATA || avs_address_i > IDX_STATUS;

  reset_clear_a: assert property (disable iff (1'h0)
    srst_i |=> !irq_o && sck_oe_n_o && mosi_oe_n_o && miso_oe_n_o && !ss_pin_free_o && avs_readdata_o == 32'h0)
    else $error("outputs not idle after reset");
  wait_one_a: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request waited more than one cycle");
  read_hold_a: assert property (!$stable(avs_readdata_o) |-> $past(avs_read_i))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (avs_read_i && avs_waitrequest_o && odd |=> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  mosi_drive_a: assert property (
    !mosi_oe_n_o |-> !sck_oe_n_o && miso_oe_n_o)
    else $error("master output driven outside master mode");
  miso_drive_a: assert property (!miso_oe_n_o |-> sck_oe_n_o)
    else $error("slave output driven in master mode");
  pin_free_a: assert property (
    st_wr |=> ss_pin_free_o == $past(avs_writedata_i[POS_SSM]))
    else $error("select pin release not as written");
  free_source_a: assert property ($changed(ss_pin_free_o) |-> $past(st_wr))
    else $error("select source changed without status write");
  fault_drop_a: assert property (
    $fell(ss_n_i) && !sck_oe_n_o && !ss_pin_free_o |-> ##[1:8] sck_oe_n_o)
    else $error("master not released after select fault");
endmodule // spisr_asserts

bind spisr_top spisr_asserts #(.BITS(BITS)) chk (
  .core_clk_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_readdata_o, .avs_waitrequest_o, .sck_oe_n_o, .mosi_oe_n_o, .miso_oe_n_o,
  .ss_n_i, .ss_pin_free_o, .irq_o
);
`default_nettype wire

/* File: verif/spisr_peer.sv */
`timescale 1ns/100ps
`default_nettype none
module spisr_peer
(
  input  wire logic  miso_i,
  output logic       sck_o,
  output logic       mosi_o,
  output logic       ss_n_o,
  output logic [7:0] rx_o
);
  initial
  begin
    sck_o = 1'h0;
    mosi_o = 1'h0;
    ss_n_o = 1'h1;
    rx_o = 8'h00;
  end
  // one mode 0 byte, 125 ns clock, idle low outside frames
  task automatic frame(input logic [7:0] tx);
    // keep pin changes off the core clock edges
    #1;
    ss_n_o = 1'h0;
    mosi_o = tx[7];
    for (int i = 7; i >= 0; i--)
    begin
      #62.5 sck_o = 1'h1;
      rx_o = {rx_o[6:0], miso_i};
      #62.5 sck_o = 1'h0;
      // released after last bit: inverse of it
      mosi_o = (i > 0) ? tx[i - 1] : ~tx[0];
    end
    #62.5 ss_n_o = 1'h1;
    // deselected gap the block can see between frames
    #62.5;
  endtask
endmodule // spisr_peer
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import spisr_pkg::*;
;
  localparam logic [7:0] DT = IDX_DATA;
  localparam logic [7:0] CT = IDX_CTRL;
  localparam logic [7:0] ST = IDX_STATUS;
  logic        clk, srst, rd, wr, ss_force_n;
  logic [7:0]  adr, p_rx;
  logic [31:0] wdat, rdat, q;
  logic        wreq, sck_p, mosi_p, ss_p, miso_w, mosi_o, miso_o, miso_oe_n, sck_oe_n, irq, sck_m;
  int          bad_count, checks_done;

  spisr_top uut (
    .core_clk_i(clk), .srst_i(srst), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .sck_i(sck_p), .sck_o(sck_m), .sck_oe_n_o(sck_oe_n), .mosi_i(mosi_p), .mosi_o(mosi_o),
    .mosi_oe_n_o(), .miso_i(mosi_o), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n),
    .ss_n_i(ss_p & ss_force_n), .ss_pin_free_o(), .irq_o(irq)
  );
  spisr_peer peer (.miso_i(miso_w), .sck_o(sck_p), .mosi_o(mosi_p), .ss_n_o(ss_p), .rx_o(p_rx));
  // released line shows the inverse of the bit
  assign miso_w = miso_oe_n ^ miso_o;

  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do @(posedge clk); while (wreq !== 1'h0);
    q = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask

  task automatic wrap_up;
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up;
  end

  initial
  begin
    srst = 1'h1;
    rd = 1'h0;
    wr = 1'h0;
    adr = 8'h00;
    wdat = 32'h0;
    ss_force_n = 1'h1;
    bad_count = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    rdc(ST, 8'h00);
    rdc(CT, 8'h00);
    rdc(8'h20, 8'h00);
    bus(1'h1, ST, 8'hF3);
    rdc(ST, 8'h03);
    // master, select internal and released
    bus(1'h1, CT, 8'h50);
    bus(1'h1, DT, 8'hA5);
    bus(1'h1, DT, 8'h3C);
    repeat (100) @(posedge clk);
    rdc(ST, 8'hC3);
    chk({31'h0, irq}, 32'h0);
    rdc(DT, 8'hA5);
    rdc(ST, 8'h03);
    bus(1'h1, CT, 8'hD0);
    bus(1'h1, DT, 8'h5A);
    repeat (100) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    bus(1'h1, DT, 8'h77);
    repeat (100) @(posedge clk);
    rdc(ST, 8'h83);
    rdc(DT, 8'h5A);
    rdc(ST, 8'h03);
    chk({31'h0, irq}, 32'h0);
    // master, clock idle high, capture on second edge
    bus(1'h1, CT, 8'h5C);
    bus(1'h1, DT, 8'h81);
    repeat (6) @(posedge clk);
    chk({31'h0, sck_m}, 32'h0);
    repeat (94) @(posedge clk);
    chk({31'h0, sck_m}, 32'h1);
    rdc(ST, 8'h83);
    rdc(DT, 8'h81);
    bus(1'h1, CT, 8'hD0);
    // select from pin, then pull it low in master mode
    bus(1'h1, ST, 8'h00);
    ss_force_n <= 1'h0;
    repeat (8) @(posedge clk);
    chk({31'h0, sck_oe_n}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rdc(ST, 8'h10);
    rdc(CT, 8'h80);
    ss_force_n <= 1'h1;
    bus(1'h1, CT, 8'h00);
    rdc(ST, 8'h00);
    // slave, two bytes without reading
    bus(1'h1, CT, 8'h40);
    bus(1'h1, DT, 8'hC3);
    peer.frame(8'h96);
    chk({24'h0, p_rx}, 32'hC3);
    peer.frame(8'h69);
    repeat (4) @(posedge clk);
    rdc(ST, 8'hA0);
    rdc(ST, 8'h80);
    rdc(DT, 8'h96);
    bus(1'h1, ST, 8'h03);
    peer.frame(8'h55);
    repeat (4) @(posedge clk);
    rdc(ST, 8'h03);
    bus(1'h1, ST, 8'h06);
    bus(1'h1, DT, 8'h5A);
    peer.frame(8'h3E);
    chk({24'h0, p_rx}, 32'hA5);
    repeat (4) @(posedge clk);
    rdc(ST, 8'h86);
    rdc(DT, 8'h3E);
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
